// ===== rtl/dcbps_seq.sv
// module: data cache unit command acceptance, bus limits and urgency toward the system bus
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// [RULE_01] urgency rises when the data cache is requesting the bus while a presented command is held off.
// [RULE_02] urgency only has meaning while a bus request is active, the bus side ignores it otherwise.
// [RULE_03] a load waiting on external data keeps urgency high for its whole request.
// [RULE_04] a store on the bus starts with urgency low and raises it once a following command is refused.
// [RULE_05] a flush on the bus raises urgency when the next command is a non-cacheable load or needs a flush.
// [RULE_06] the arbiter treats high urgency as a demand for immediate service.
// [RULE_07] fills, flushes, word accesses and hits run at the same time without serialising each other.
// [RULE_08] commands other than loads and stores wait until all earlier bus work has finished.
// [RULE_09] hitting loads and stores are taken one per cycle.
// [RULE_10] non-cacheable loads are issued no closer than four cycles apart.
// [RULE_11] non-cacheable stores are issued every other cycle at best, with at most three outstanding.
// [RULE_12] a load, store or touch miss starts a line fill, with at most two fills outstanding.
// [RULE_13] held commands wait for the first fill to finish and fills finish in bus order.
// [RULE_14] a flush is raised for a fill that evicts a dirty line or for a flush-line command.
// [RULE_15] with two flushes pending new commands stall until the first ends and the second has begun.
// [RULE_16] writing a fill buffer into the arrays takes three cycles, four for a dirty victim, and stalls commands.
// [RULE_17] urgency is low whenever no bus request is outstanding.
module dcbps_seq (
    input  wire logic                          clk_in,
    input  wire logic                          rst_n_in,
    // pipeline command
    input  wire logic                          cmd_valid_in,
    input  wire logic [dcbps_pkg::CMD_W-1:0]   cmd_kind_in,
    input  wire logic                          cmd_hit_in,
    input  wire logic                          cmd_noncache_in,
    input  wire logic                          cmd_dirty_in,
    output logic                               cmd_ready_out,
    // system bus line fill
    output logic                               fill_req_out,
    input  wire logic                          fill_ack_in,
    input  wire logic                          fill_done_in,
    // system bus line flush
    output logic                               flush_req_out,
    input  wire logic                          flush_ack_in,
    input  wire logic                          flush_done_in,
    // system bus single word store
    output logic                               wstore_req_out,
    input  wire logic                          wstore_ack_in,
    input  wire logic                          wstore_done_in,
    // system bus single word load
    output logic                               wload_req_out,
    input  wire logic                          wload_ack_in,
    input  wire logic                          wload_done_in,
    // urgency toward the arbiter
    output logic                               bus_urgent_out
);

    // ====================
    // reset release through two flops
    // ====================
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ====================
    // bus trackers
    // ====================
    logic [dcbps_pkg::NTRK-1:0] trk_push;
    logic [dcbps_pkg::NTRK-1:0] trk_ack;
    logic [dcbps_pkg::NTRK-1:0] trk_done;
    logic [dcbps_pkg::NTRK-1:0] trk_nreq;
    logic [dcbps_pkg::NTRK-1:0] trk_req;
    logic [dcbps_pkg::NTRK-1:0] trk_full;
    logic [dcbps_pkg::NTRK-1:0] trk_busy;
    logic [dcbps_pkg::NTRK-1:0] trk_pend;

    assign trk_ack  = {wload_ack_in, wstore_ack_in, flush_ack_in, fill_ack_in};
    assign trk_done = {wload_done_in, wstore_done_in, flush_done_in, fill_done_in};

    // one tracker per class keeps them independent so they overlap freely
    for (genvar i = 0; i < dcbps_pkg::NTRK; i++) begin : g_trk
        dcbps_track #(
            .LIMIT (dcbps_pkg::TRK_LIMIT[i]),       // RULE_11
            .GAP   (dcbps_pkg::TRK_GAP[i])          // RULE_10
        ) u_trk (
            .clk_in   (clk_in),
            .rst_n_in (rst_n),
            .push_in  (trk_push[i]),
            .ack_in   (trk_ack[i]),
            .done_in  (trk_done[i]),
            .req_next_out (trk_nreq[i]),
            .req_out  (trk_req[i]),
            .full_out (trk_full[i]),
            .busy_out (trk_busy[i]),
            .pend_out (trk_pend[i])
        );
    end

    assign fill_req_out   = trk_req[dcbps_pkg::TRK_FILL];
    assign flush_req_out  = trk_req[dcbps_pkg::TRK_FLUSH];
    assign wstore_req_out = trk_req[dcbps_pkg::TRK_STORE];
    assign wload_req_out  = trk_req[dcbps_pkg::TRK_LOAD];

    // ====================
    // command classification
    // ====================
    function automatic logic is_ldst(input logic [dcbps_pkg::CMD_W-1:0] k);
        is_ldst = (k == dcbps_pkg::CMD_LOAD) || (k == dcbps_pkg::CMD_STORE);
    endfunction
    function automatic logic needs_flush(input logic [dcbps_pkg::CMD_W-1:0] k, input logic dirty);
        needs_flush = (k == dcbps_pkg::CMD_FLUSH) || ((k == dcbps_pkg::CMD_STLN) && dirty);
    endfunction

    logic c_ldst;
    logic c_fill;
    logic c_flush;
    logic c_wload;
    logic c_wstore;

    // cacheable load, store and touch misses fill; non-cacheable loads and stores go word by word
    always_comb begin
        c_ldst   = is_ldst(cmd_kind_in);
        c_wload  = (cmd_kind_in == dcbps_pkg::CMD_LOAD) && cmd_noncache_in;
        c_wstore = (cmd_kind_in == dcbps_pkg::CMD_STORE) && cmd_noncache_in;
        c_fill   = !cmd_hit_in && !cmd_noncache_in
                   && (c_ldst || cmd_kind_in == dcbps_pkg::CMD_TOUCH);    // RULE_12
        c_flush  = needs_flush(cmd_kind_in, cmd_dirty_in)
                   || (c_fill && cmd_dirty_in);                           // RULE_14
    end

    // ====================
    // fill order record: dirty victim and load flag per outstanding fill
    // ====================
    logic [dcbps_pkg::FIFO_D-1:0] fifo_vld;
    logic [dcbps_pkg::FIFO_D-1:0] fifo_dirty;
    logic [dcbps_pkg::FIFO_D-1:0] fifo_load;
    logic [dcbps_pkg::FIFO_D-1:0] next_fifo_vld;
    logic [dcbps_pkg::FIFO_D-1:0] next_fifo_dirty;
    logic [dcbps_pkg::FIFO_D-1:0] next_fifo_load;

    // the bus returns fills in accept order, so the head always matches the finishing fill
    always_comb begin
        next_fifo_vld   = fifo_vld;
        next_fifo_dirty = fifo_dirty;
        next_fifo_load  = fifo_load;
        if (fill_done_in) begin                                           // RULE_13
            next_fifo_vld   = {1'b0, fifo_vld[1]};
            next_fifo_dirty = {1'b0, fifo_dirty[1]};
            next_fifo_load  = {1'b0, fifo_load[1]};
        end
        if (trk_push[dcbps_pkg::TRK_FILL]) begin
            if (!next_fifo_vld[0]) begin
                next_fifo_vld[0]   = 1'b1;
                next_fifo_dirty[0] = cmd_dirty_in;
                next_fifo_load[0]  = cmd_kind_in == dcbps_pkg::CMD_LOAD;
            end else begin
                next_fifo_vld[1]   = 1'b1;
                next_fifo_dirty[1] = cmd_dirty_in;
                next_fifo_load[1]  = cmd_kind_in == dcbps_pkg::CMD_LOAD;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            fifo_vld   <= '0;
            fifo_dirty <= '0;
            fifo_load  <= '0;
        end else begin
            fifo_vld   <= next_fifo_vld;
            fifo_dirty <= next_fifo_dirty;
            fifo_load  <= next_fifo_load;
        end
    end

    // ====================
    // fill buffer to array write sequencer
    // ====================
    dcbps_pkg::dcbps_wr_t       wr_state;
    dcbps_pkg::dcbps_wr_t       next_wr_state;
    logic [dcbps_pkg::WR_W-1:0] wr_cnt;
    logic [dcbps_pkg::WR_W-1:0] next_wr_cnt;

    // busy for exactly the transfer length, starting the cycle after the fill ends
    always_comb begin
        next_wr_state = wr_state;
        next_wr_cnt   = wr_cnt;
        unique case (wr_state)
            dcbps_pkg::WR_IDLE: begin
                if (fill_done_in) begin
                    next_wr_state = dcbps_pkg::WR_BUSY;
                    next_wr_cnt   = (fifo_dirty[0] ? dcbps_pkg::WR_CYC_DIRTY
                                                   : dcbps_pkg::WR_CYC_CLEAN) - 1'b1;   // RULE_16
                end
            end
            dcbps_pkg::WR_BUSY: begin
                if (wr_cnt == '0) begin
                    next_wr_state = dcbps_pkg::WR_IDLE;
                end else begin
                    next_wr_cnt = wr_cnt - 1'b1;
                end
            end
            default: begin
                next_wr_state = dcbps_pkg::WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            wr_state <= dcbps_pkg::WR_IDLE;
            wr_cnt   <= '0;
        end else begin
            wr_state <= next_wr_state;
            wr_cnt   <= next_wr_cnt;
        end
    end

    // ====================
    // flush hold: once two are pending, stay stalled until the second has begun
    // ====================
    logic flush_hold;
    logic next_flush_hold;
    always_comb begin
        next_flush_hold = flush_hold;
        if (trk_full[dcbps_pkg::TRK_FLUSH]) begin
            next_flush_hold = 1'b1;
        end else if (!trk_pend[dcbps_pkg::TRK_FLUSH]) begin
            next_flush_hold = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            flush_hold <= 1'b0;
        end else begin
            flush_hold <= next_flush_hold;
        end
    end

    // ====================
    // acceptance
    // ====================
    logic stall;
    logic take;

    // the array write and the flush limit hold off every command, open bus work any non-load/store; other limits only commands that touch them
    always_comb begin
        stall = (wr_state == dcbps_pkg::WR_BUSY);                          // RULE_16
        stall = stall || trk_full[dcbps_pkg::TRK_FLUSH]
                      || (flush_hold && trk_pend[dcbps_pkg::TRK_FLUSH]);  // RULE_15
        stall = stall || (!c_ldst && (|trk_busy));                         // RULE_08
        stall = stall || (c_fill && trk_full[dcbps_pkg::TRK_FILL]);        // RULE_12 RULE_13
        stall = stall || (c_wstore && trk_full[dcbps_pkg::TRK_STORE]);     // RULE_11
        stall = stall || (c_wload && trk_full[dcbps_pkg::TRK_LOAD]);       // RULE_10
        take  = cmd_valid_in && !stall;                                    // RULE_09 RULE_07
        trk_push[dcbps_pkg::TRK_FILL]  = take && c_fill;
        trk_push[dcbps_pkg::TRK_FLUSH] = take && c_flush;                  // RULE_14
        trk_push[dcbps_pkg::TRK_STORE] = take && c_wstore;
        trk_push[dcbps_pkg::TRK_LOAD]  = take && c_wload;
    end

    // ready is a decision on the command in hand, so it cannot be a registered guess
    assign cmd_ready_out = !stall;

    // ====================
    // urgency, from next request levels so the flag never lags or outlives a request
    // ====================
    logic next_urgent;
    logic any_req;
    logic load_wait;
    logic flush_push;

    always_comb begin
        any_req     = |trk_nreq;
        load_wait   = trk_nreq[dcbps_pkg::TRK_LOAD]
                      || (|(next_fifo_vld & next_fifo_load));              // RULE_03
        flush_push  = trk_busy[dcbps_pkg::TRK_FLUSH] && cmd_valid_in
                      && (c_wload || c_flush);                             // RULE_05
        next_urgent = load_wait || (cmd_valid_in && stall) || flush_push;  // RULE_01 RULE_04
        next_urgent = next_urgent && any_req;                              // RULE_02 RULE_17
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            bus_urgent_out <= 1'b0;
        end else begin
            bus_urgent_out <= next_urgent;
        end
    end

endmodule

`default_nettype wire

// ===== rtl/dcbps_pkg.sv
// package: constants and command encodings for the data cache bus priority sequencer
package dcbps_pkg;

    // =====================================================================
    // command kinds presented by the pipeline
    // =====================================================================
    localparam int             CMD_W       = 3;
    localparam logic [CMD_W-1:0] CMD_LOAD  = 3'h0;
    localparam logic [CMD_W-1:0] CMD_STORE = 3'h1;
    localparam logic [CMD_W-1:0] CMD_TOUCH = 3'h2;  // touch line, fills on miss
    localparam logic [CMD_W-1:0] CMD_FLUSH = 3'h3;  // flush line to memory
    localparam logic [CMD_W-1:0] CMD_STLN  = 3'h4;  // store line, keep copy
    localparam logic [CMD_W-1:0] CMD_INVAL = 3'h5;  // invalidate / congruence clear
    localparam logic [CMD_W-1:0] CMD_ZERO  = 3'h6;  // zero line

    // =====================================================================
    // bus trackers: index, outstanding limit, request spacing in cycles
    // =====================================================================
    localparam int NTRK      = 4;
    localparam int TRK_FILL  = 0;
    localparam int TRK_FLUSH = 1;
    localparam int TRK_STORE = 2;
    localparam int TRK_LOAD  = 3;
    localparam int CNT_W     = 2;
    localparam int GAP_W     = 3;
    localparam int TRK_LIMIT [0:NTRK-1] = '{2, 2, 3, 1};
    localparam int TRK_GAP   [0:NTRK-1] = '{1, 1, 2, 4};

    // =====================================================================
    // fill buffer to array transfer, in clock cycles
    // =====================================================================
    localparam int               WR_W         = 3;
    localparam logic [WR_W-1:0]  WR_CYC_CLEAN = 3'h3;
    localparam logic [WR_W-1:0]  WR_CYC_DIRTY = 3'h4;
    localparam int               FIFO_D       = 2;

    // array write sequencer states, one-hot
    typedef enum logic [1:0] {
        WR_IDLE = 2'h1,
        WR_BUSY = 2'h2
    } dcbps_wr_t;

endpackage

// ===== rtl/dcbps_track.sv
// module: outstanding-operation tracker for one class of bus request
`timescale 1ns/100ps
`default_nettype none

module dcbps_track #(
    parameter int LIMIT = 2,
    parameter int GAP   = 1
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic push_in,
    input  wire logic ack_in,
    input  wire logic done_in,
    output logic      req_next_out,
    output logic      req_out,
    output logic      full_out,
    output logic      busy_out,
    output logic      pend_out
);

    logic [dcbps_pkg::CNT_W-1:0] total;
    logic [dcbps_pkg::CNT_W-1:0] pend;
    logic [dcbps_pkg::GAP_W-1:0] gap;
    logic [dcbps_pkg::CNT_W-1:0] next_total;
    logic [dcbps_pkg::CNT_W-1:0] next_pend;
    logic [dcbps_pkg::GAP_W-1:0] next_gap;

    // ====================
    // counts: total in flight, not yet accepted by the bus, spacing gap
    // ====================
    always_comb begin
        next_total = total;
        next_pend  = pend;
        next_gap   = gap;
        if (push_in && !done_in) begin
            next_total = total + 1'b1;
        end else if (!push_in && done_in && total != '0) begin
            next_total = total - 1'b1;
        end
        if (push_in && !ack_in) begin
            next_pend = pend + 1'b1;
        end else if (!push_in && ack_in && pend != '0) begin
            next_pend = pend - 1'b1;
        end
        // request held low for GAP-1 cycles after an accept so that issue rate is bounded
        if (ack_in) begin
            next_gap = dcbps_pkg::GAP_W'(GAP - 1);
        end else if (gap != '0) begin
            next_gap = gap - 1'b1;
        end
    end

    // request level one cycle ahead, so urgency can be registered beside it
    assign req_next_out = (next_pend != '0) && (next_gap == '0);

    // registered state and outputs, all taken from next values
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            total    <= '0;
            pend     <= '0;
            gap      <= '0;
            req_out  <= 1'b0;
            full_out <= 1'b0;
            busy_out <= 1'b0;
            pend_out <= 1'b0;
        end else begin
            total    <= next_total;
            pend     <= next_pend;
            gap      <= next_gap;
            req_out  <= req_next_out;
            full_out <= next_total == dcbps_pkg::CNT_W'(LIMIT);
            busy_out <= next_total != '0;
            pend_out <= next_pend != '0;
        end
    end

endmodule

`default_nettype wire

// ===== test/dcbps_seq_chk.sv
// checker: port-level properties of the data cache bus priority sequencer
`timescale 1ns/100ps
`default_nettype none

module dcbps_seq_chk (
    input wire logic                        clk_in,
    input wire logic                        rst_n_in,
    input wire logic                        cmd_valid_in,
    input wire logic [dcbps_pkg::CMD_W-1:0] cmd_kind_in,
    input wire logic                        cmd_hit_in,
    input wire logic                        cmd_noncache_in,
    input wire logic                        cmd_dirty_in,
    input wire logic                        cmd_ready_out,
    input wire logic                        fill_req_out,
    input wire logic                        fill_ack_in,
    input wire logic                        fill_done_in,
    input wire logic                        flush_req_out,
    input wire logic                        flush_ack_in,
    input wire logic                        flush_done_in,
    input wire logic                        wstore_req_out,
    input wire logic                        wstore_ack_in,
    input wire logic                        wstore_done_in,
    input wire logic                        wload_req_out,
    input wire logic                        wload_ack_in,
    input wire logic                        wload_done_in,
    input wire logic                        bus_urgent_out
);
    logic       any_req;
    logic [2:0] fill_cnt;
    logic [2:0] flush_cnt;
    logic [2:0] store_cnt;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // ====================
    // acked but unfinished work; a lower bound on what the block tracks
    // ====================
    assign any_req = fill_req_out | flush_req_out | wstore_req_out | wload_req_out;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fill_cnt  <= 3'h0;
            flush_cnt <= 3'h0;
            store_cnt <= 3'h0;
        end else begin
            fill_cnt  <= fill_cnt + 3'(fill_ack_in & fill_req_out) - 3'(fill_done_in && fill_cnt != 3'h0);
            flush_cnt <= flush_cnt + 3'(flush_ack_in & flush_req_out) - 3'(flush_done_in && flush_cnt != 3'h0);
            store_cnt <= store_cnt + 3'(wstore_ack_in & wstore_req_out) - 3'(wstore_done_in && store_cnt != 3'h0);
        end
    end

    // ====================
    // properties
    // ====================
    property p_urg_req; bus_urgent_out |-> any_req; endproperty
    a_urg_req: assert property (p_urg_req) else $error("urgency high with no request");
    property p_nc_load_urg; wload_req_out |-> bus_urgent_out; endproperty
    a_nc_load_urg: assert property (p_nc_load_urg) else $error("word load without urgency");
    property p_nc_load_gap; wload_ack_in && wload_req_out |=> !wload_req_out [*3]; endproperty
    a_nc_load_gap: assert property (p_nc_load_gap) else $error("word loads closer than four");
    property p_refuse_urg; (cmd_valid_in && !cmd_ready_out) ##1 any_req |-> bus_urgent_out; endproperty
    a_refuse_urg: assert property (p_refuse_urg) else $error("stall without urgency");
    property p_store_lim;
        store_cnt == 3'h3 && cmd_valid_in && cmd_kind_in == dcbps_pkg::CMD_STORE && cmd_noncache_in |-> !cmd_ready_out;
    endproperty
    a_store_lim: assert property (p_store_lim) else $error("fourth word store taken");
    property p_fill_lim;
        fill_cnt == 3'h2 && cmd_valid_in && !cmd_hit_in && !cmd_noncache_in
            && cmd_kind_in <= dcbps_pkg::CMD_TOUCH |-> !cmd_ready_out;
    endproperty
    a_fill_lim: assert property (p_fill_lim) else $error("third fill taken");
    property p_other_wait;
        cmd_valid_in && cmd_kind_in > dcbps_pkg::CMD_STORE && (any_req || fill_cnt != 3'h0) |-> !cmd_ready_out;
    endproperty
    a_other_wait: assert property (p_other_wait) else $error("cache op taken with bus busy");
    property p_array_wr; fill_done_in && fill_cnt != 3'h0 |=> !cmd_ready_out [*3]; endproperty
    a_array_wr: assert property (p_array_wr) else $error("command taken during array write");
    property p_flush_lim; flush_cnt == 3'h2 && cmd_valid_in |-> !cmd_ready_out; endproperty
    a_flush_lim: assert property (p_flush_lim) else $error("command taken with two flushes");
endmodule

bind dcbps_seq dcbps_seq_chk u_chk (.clk_in, .rst_n_in, .cmd_valid_in, .cmd_kind_in, .cmd_hit_in,
    .cmd_noncache_in, .cmd_dirty_in, .cmd_ready_out, .fill_req_out, .fill_ack_in, .fill_done_in,
    .flush_req_out, .flush_ack_in, .flush_done_in, .wstore_req_out, .wstore_ack_in, .wstore_done_in,
    .wload_req_out, .wload_ack_in, .wload_done_in, .bus_urgent_out);
`default_nettype wire

// ===== test/dcbps_bus_model.sv
// partner model: one system bus channel that accepts requests and completes them in order
`timescale 1ns/100ps
`default_nettype none

module dcbps_bus_model #(
    parameter int DONE_LAT = 2
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic req_in,
    input  wire logic urgent_in,
    input  wire logic slow_in,
    output logic      ack_out,
    output logic      done_out
);
    logic [3:0] wait_cnt;
    logic [3:0] pend;
    logic [3:0] lat;

    // ====================
    // slow mode stalls acceptance up to 15 cycles unless urgency is shown
    // ====================
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_out  <= 1'b0;
            done_out <= 1'b0;
            wait_cnt <= 4'h0;
            pend     <= 4'h0;
            lat      <= 4'h0;
        end else begin
            ack_out  <= req_in && !ack_out && (urgent_in || !slow_in || wait_cnt == 4'hf);
            wait_cnt <= (req_in && !ack_out) ? wait_cnt + 4'h1 : 4'h0;
            pend     <= pend + 4'(ack_out) - 4'(done_out);
            done_out <= !done_out && pend != 4'h0 && lat >= 4'(DONE_LAT);
            lat      <= (pend != 4'h0 && !done_out) ? lat + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

// ===== test/data_cache_bus_priority_sequencer_bench.sv
// testbench: command table and bursts against the sequencer with four channel models
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin error_cnt++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end

module data_cache_bus_priority_sequencer_bench;
    localparam int LAT [0:3] = '{1, 12, 3, 12};   // word load, word store, flush, fill
    logic        clk_in       = 1'b0;
    logic        rst_n        = 1'b0;
    logic        slow         = 1'b0;
    logic [6:0]  cmd          = 7'h0;   // valid, kind, hit, noncache, dirty
    logic [15:0] seed         = 16'h0041;
    logic        ready;
    logic        urgent;
    logic [3:0]  req;                   // fill, flush, wstore, wload
    logic [3:0]  ack;
    logic [3:0]  done;
    logic [4:0]  note;
    logic [4:0]  notes [$];
    int          outst        = 0;
    int          error_cnt    = 0;
    int          total_checks = 0;
    int          cnt;
    logic        u;

    always #2 clk_in = ~clk_in;

    dcbps_seq u_dut (.clk_in(clk_in), .rst_n_in(rst_n), .cmd_valid_in(cmd[6]), .cmd_kind_in(cmd[5:3]),
        .cmd_hit_in(cmd[2]), .cmd_noncache_in(cmd[1]), .cmd_dirty_in(cmd[0]), .cmd_ready_out(ready),
        .fill_req_out(req[3]), .fill_ack_in(ack[3]), .fill_done_in(done[3]),
        .flush_req_out(req[2]), .flush_ack_in(ack[2]), .flush_done_in(done[2]),
        .wstore_req_out(req[1]), .wstore_ack_in(ack[1]), .wstore_done_in(done[1]),
        .wload_req_out(req[0]), .wload_ack_in(ack[0]), .wload_done_in(done[0]), .bus_urgent_out(urgent));

    // ====================
    // far side: one model per channel, fills held long to expose the limits
    // ====================
    for (genvar g = 0; g < 4; g++) begin : g_bus
        dcbps_bus_model #(.DONE_LAT(LAT[g])) u_bus (.clk_in(clk_in), .rst_n_in(rst_n), .req_in(req[g]),
            .urgent_in(urgent), .slow_in(slow), .ack_out(ack[g]), .done_out(done[g]));
    end

    // accepted but unfinished bus work, so idle waits know when to stop
    always @(posedge clk_in) outst <= outst + $countones(ack) - $countones(done);

    // each taken command's first-cycle bus picture is held against the oldest note
    always @(posedge clk_in) begin
        if (cmd[6] && ready && notes.size() != 0) begin
            note = notes.pop_front();
            #1;
            `CHK("req_urgent", note, {req, urgent})
        end
    end

    function automatic logic [15:0] xs(input logic [15:0] s);
        logic [15:0] t;
        t = s ^ (s << 7);
        t = t ^ (t >> 9);
        return t ^ (t << 8);
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // offer one command, hold it until taken, then watch the bus go quiet
    task automatic issue(input logic [2:0] k, input logic h, n, d, input logic [4:0] nxt, input logic [3:0] all);
        logic [3:0] seen;
        seen = 4'h0;
        notes.push_back(nxt);
        cmd <= {1'b1, k, h, n, d};
        do @(posedge clk_in); while (!ready);
        cmd <= 7'h0;
        do begin
            @(posedge clk_in);
            seen |= req;
        end while (req != 4'h0 || outst != 0);
        repeat (6) @(posedge clk_in);   // let an array write run out
        `CHK("bus_seen", all, seen)
    endtask

    // present a command every cycle; hits get random kind and dirty bits
    task automatic burst(input logic [2:0] k, input logic h, n, input int cyc);
        cnt = 0;
        u = 1'b0;
        for (int i = 0; i < cyc; i++) begin
            seed = xs(seed);
            cmd <= {1'b1, h ? {2'b00, seed[0]} : k, h, n, h & seed[1]};
            @(posedge clk_in);
            if (ready) cnt++;
            if (urgent) u = 1'b1;
        end
        while (!ready) @(posedge clk_in);
        cmd <= 7'h0;
        while (req != 4'h0 || outst != 0) @(posedge clk_in);
        repeat (6) @(posedge clk_in);
    endtask

    initial begin
        #(5000 * 4);
        error_cnt++;
        close_out();
    end

    initial begin
        repeat (6) @(posedge clk_in);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_in);
        slow <= 1'b1;
        issue(dcbps_pkg::CMD_LOAD, 1, 0, 0, 5'h00, 4'h0);
        issue(dcbps_pkg::CMD_LOAD, 0, 0, 0, 5'h11, 4'h8);
        issue(dcbps_pkg::CMD_LOAD, 0, 0, 1, 5'h19, 4'hc);
        issue(dcbps_pkg::CMD_STORE, 0, 0, 0, 5'h10, 4'h8);
        issue(dcbps_pkg::CMD_TOUCH, 0, 0, 0, 5'h10, 4'h8);
        issue(dcbps_pkg::CMD_STORE, 0, 1, 0, 5'h04, 4'h2);
        issue(dcbps_pkg::CMD_LOAD, 0, 1, 0, 5'h03, 4'h1);
        issue(dcbps_pkg::CMD_FLUSH, 0, 0, 1, 5'h08, 4'h4);
        issue(dcbps_pkg::CMD_STLN, 0, 0, 1, 5'h08, 4'h4);
        issue(dcbps_pkg::CMD_INVAL, 0, 0, 0, 5'h00, 4'h0);
        issue(dcbps_pkg::CMD_ZERO, 0, 0, 0, 5'h00, 4'h0);
        slow <= 1'b0;
        burst(dcbps_pkg::CMD_LOAD, 1, 0, 8);
        `CHK("hit_takes", 8, cnt)
        `CHK("hit_urgent", 1'b0, u)
        burst(dcbps_pkg::CMD_STORE, 0, 1, 8);
        `CHK("store_takes", 3, cnt)
        `CHK("store_urgent", 1'b1, u)
        burst(dcbps_pkg::CMD_LOAD, 0, 0, 8);
        `CHK("fill_takes", 2, cnt)
        burst(dcbps_pkg::CMD_LOAD, 0, 1, 20);
        `CHK("ncload_rate", 1'b1, cnt >= 2 && cnt <= 6)
        close_out();
    end
endmodule
`default_nettype wire
